// ### design/fpes_pkg.sv
// Shared constants and types for the flash program and erase sequencer.
package fpes_pkg;
  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_KEY = 3'h1;
  localparam logic [2:0] ADDR_ADR_LO = 3'h2;
  localparam logic [2:0] ADDR_ADR_HI = 3'h3;
  localparam logic [2:0] ADDR_LATCH_LO = 3'h4;
  localparam logic [2:0] ADDR_LATCH_HI = 3'h5;
  localparam logic [2:0] ADDR_LATCH_IDX = 3'h6;
  localparam logic [2:0] ADDR_MODE = 3'h7;
  // Control register field positions.
  localparam int BIT_START = 15;
  localparam int BIT_ENABLE = 14;
  localparam int BIT_SEQERR = 13;
  localparam int BIT_SWAP = 11;
  localparam int BIT_P2ACT = 10;
  // Operation select codes.
  localparam logic [3:0] OP_DWORD = 4'h1;
  localparam logic [3:0] OP_ROW = 4'h2;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] OP_INACT_ERASE = 4'h4;
  localparam logic [3:0] OP_BOOT_CFG = 4'h8;
  localparam logic [3:0] OP_CHIP_ERASE = 4'he;
  // Unlock key values.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Latch geometry and boot word width.
  localparam int LATCH_WORDS = 128;
  localparam int WORD_BITS = 24;
  localparam int BOOT_BITS = 48;
  // Fixed address used by operations that ignore the target address.
  localparam logic [23:0] FIXED_ADDR = 24'h00_0000;
  // Self-timed operation length in ns and the derived cycle count at 200 MHz.
  localparam int OP_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] ZERO16 = 16'h0000;

  typedef enum logic [1:0] {FPES_IDLE, FPES_KEY1, FPES_ARMED} fpes_key_t;
  typedef enum logic [1:0] {FPES_RUN_IDLE, FPES_RUN_BUSY} fpes_run_t;

  // Request latched at launch and driven on the commit outputs.
  typedef struct packed {
    logic [3:0] op;
    logic [23:0] addr;
    logic stall;
  } fpes_req_t;
endpackage

// ### design/fpes_timer.sv
// Self-timed operation counter for the flash sequencer.
`timescale 1ns/100ps
module fpes_timer #(
  parameter int CYCLES = fpes_pkg::OP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_go,
  output logic o_done,
  output logic o_busy
);
  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
    logic done;
  } fpes_tmr_st_t;
  fpes_tmr_st_t s_q;
  fpes_tmr_st_t s_d;

  // Load the count on go, count down, pulse done at the end.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (i_go && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.cnt = 16'(CYCLES - 1);
    end else if (s_q.busy) begin
      if (s_q.cnt == fpes_pkg::ZERO16) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_done = s_q.done;
  assign o_busy = s_q.busy;
endmodule

// ### design/fpes_seq.sv
// Flash program and erase sequencer with control, key, address and latch registers.
`timescale 1ns/100ps
module fpes_seq #(
  parameter int OP_CYC = fpes_pkg::OP_CYCLES,
  parameter int NWORDS = fpes_pkg::LATCH_WORDS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_por_b,
  input wire logic i_dual_mode,
  input wire logic i_swap_event,
  input wire logic i_p2_active,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_stall,
  output logic o_busy,
  output logic o_commit,
  output logic [3:0] o_commit_op,
  output logic [23:0] o_commit_addr,
  output logic [23:0] o_commit_word0,
  output logic [23:0] o_commit_word1,
  output logic o_boot_pending
);
  localparam int IW = $clog2(NWORDS);

  typedef struct packed {
    logic start;
    logic enable;
    logic seqerr;
    logic swap;
    logic [3:0] op;
    logic [7:0] adr_hi;
    logic [15:0] adr_lo;
    logic [IW-1:0] idx;
    fpes_pkg::fpes_key_t key;
    fpes_pkg::fpes_run_t run;
    logic [15:0] rdata;
    logic stall;
    logic go;
    logic commit;
    fpes_pkg::fpes_req_t req;
    logic [23:0] w0;
    logic [23:0] w1;
    logic boot;
  } fpes_st_t;

  fpes_st_t s_q;
  fpes_st_t s_d;
  logic [23:0] latch_q [NWORDS];
  logic done;
  logic tbusy;

  // Decode of implemented and currently legal operation codes.
  function automatic logic op_legal(input logic [3:0] op, input logic dual);
    unique case (op)
      fpes_pkg::OP_DWORD, fpes_pkg::OP_ROW, fpes_pkg::OP_PAGE_ERASE,
      fpes_pkg::OP_BOOT_CFG, fpes_pkg::OP_CHIP_ERASE: op_legal = 1'b1;
      fpes_pkg::OP_INACT_ERASE: op_legal = dual;
      default: op_legal = 1'b0;
    endcase
  endfunction

  // Control register image as software reads it.
  function automatic logic [15:0] ctrl_img(input fpes_st_t s, input logic dual,
                                           input logic p2);
    logic [15:0] v;
    v = fpes_pkg::ZERO16;
    v[fpes_pkg::BIT_START] = s.start;
    v[fpes_pkg::BIT_ENABLE] = s.enable;
    v[fpes_pkg::BIT_SEQERR] = s.seqerr;
    v[fpes_pkg::BIT_SWAP] = s.swap & dual;
    v[fpes_pkg::BIT_P2ACT] = p2 & dual;
    v[3:0] = s.op;
    ctrl_img = v;
  endfunction

  fpes_timer #(
    .CYCLES(OP_CYC)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_b(i_por_b), // Power-on only, so a warm reset cannot strand an operation.
    .i_go(s_q.go),
    .o_done(done),
    .o_busy(tbusy)
  );

  // Register writes, unlock sequence, launch and completion.
  always_comb begin
    logic legal;
    logic [23:0] tgt;
    legal = 1'b0;
    tgt = {s_q.adr_hi, s_q.adr_lo};
    s_d = s_q;
    s_d.go = 1'b0;
    s_d.commit = 1'b0;
    s_d.rdata = fpes_pkg::ZERO16;
    if (i_rd) begin
      unique case (i_addr)
        fpes_pkg::ADDR_CTRL: s_d.rdata = ctrl_img(s_q, i_dual_mode, i_p2_active);
        fpes_pkg::ADDR_ADR_LO: s_d.rdata = s_q.adr_lo;
        fpes_pkg::ADDR_ADR_HI: s_d.rdata = {8'h00, s_q.adr_hi};
        fpes_pkg::ADDR_LATCH_IDX: s_d.rdata = 16'(s_q.idx);
        fpes_pkg::ADDR_MODE: s_d.rdata = {15'h0000, s_q.boot};
        default: s_d.rdata = fpes_pkg::ZERO16; // Key reads as zero.
      endcase
    end
    // Any access other than the second key breaks an armed sequence.
    if ((i_wr || i_rd) && !(i_wr && i_addr == fpes_pkg::ADDR_KEY)) begin
      if (!(i_wr && i_addr == fpes_pkg::ADDR_CTRL)) begin
        s_d.key = fpes_pkg::FPES_IDLE;
      end
    end
    if (i_wr && s_q.run == fpes_pkg::FPES_RUN_IDLE) begin
      unique case (i_addr)
        fpes_pkg::ADDR_KEY: begin
          if (i_wdata[7:0] == fpes_pkg::KEY_FIRST) begin
            s_d.key = fpes_pkg::FPES_KEY1;
          end else if (i_wdata[7:0] == fpes_pkg::KEY_SECOND &&
                       s_q.key == fpes_pkg::FPES_KEY1) begin
            s_d.key = fpes_pkg::FPES_ARMED;
          end else begin
            s_d.key = fpes_pkg::FPES_IDLE;
          end
        end
        fpes_pkg::ADDR_CTRL: begin
          s_d.enable = i_wdata[fpes_pkg::BIT_ENABLE];
          s_d.op = i_wdata[3:0];
          if (!i_wdata[fpes_pkg::BIT_SWAP]) begin
            s_d.swap = 1'b0;
          end
          s_d.key = fpes_pkg::FPES_IDLE;
          if (i_wdata[fpes_pkg::BIT_START]) begin
            legal = op_legal(i_wdata[3:0], i_dual_mode);
            if (s_q.key == fpes_pkg::FPES_ARMED && s_q.enable &&
                i_wdata[fpes_pkg::BIT_ENABLE] && legal) begin
              s_d.start = 1'b1;
              s_d.seqerr = 1'b0;
              s_d.run = fpes_pkg::FPES_RUN_BUSY;
              s_d.go = 1'b1;
              s_d.req.op = i_wdata[3:0];
              if (i_wdata[3:0] == fpes_pkg::OP_CHIP_ERASE ||
                  i_wdata[3:0] == fpes_pkg::OP_INACT_ERASE) begin
                tgt = fpes_pkg::FIXED_ADDR;
              end
              s_d.req.addr = tgt;
              // Only the inactive-partition erase runs beside the core.
              s_d.req.stall = !(i_dual_mode &&
                                i_wdata[3:0] == fpes_pkg::OP_INACT_ERASE);
              s_d.stall = s_d.req.stall;
            end else begin
              s_d.seqerr = 1'b1;
            end
          end
        end
        fpes_pkg::ADDR_ADR_LO: s_d.adr_lo = i_wdata;
        fpes_pkg::ADDR_ADR_HI: s_d.adr_hi = i_wdata[7:0];
        fpes_pkg::ADDR_LATCH_IDX: s_d.idx = i_wdata[IW-1:0];
        default: begin
        end
      endcase
    end
    // Completion clears start, releases the core and commits latches.
    if (done) begin
      s_d.start = 1'b0;
      s_d.stall = 1'b0;
      s_d.run = fpes_pkg::FPES_RUN_IDLE;
      s_d.commit = 1'b1;
      s_d.w0 = latch_q[0];
      s_d.w1 = latch_q[1];
      if (s_q.req.op == fpes_pkg::OP_BOOT_CFG) begin
        s_d.boot = 1'b1;
      end
    end
    // Hardware set of the swap bit wins over a software clear.
    if (i_swap_event && i_dual_mode) begin
      s_d.swap = 1'b1;
    end
  end

  // Control fields except swap survive warm reset, which clears swap; only power-on clears the rest.
  always_ff @(posedge i_clk or negedge i_por_b) begin
    if (!i_por_b) begin
      s_q <= '0;
    end else if (!i_rst_b) begin
      s_q <= s_d;
      s_q.swap <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Table-write holding latches; array only sees them on commit.
  always_ff @(posedge i_clk) begin
    if (i_wr && i_addr == fpes_pkg::ADDR_LATCH_LO) begin
      latch_q[s_q.idx][15:0] <= i_wdata;
    end
    if (i_wr && i_addr == fpes_pkg::ADDR_LATCH_HI) begin
      latch_q[s_q.idx][23:16] <= i_wdata[7:0];
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_stall = s_q.stall;
  assign o_busy = s_q.start;
  assign o_commit = s_q.commit;
  assign o_commit_op = s_q.req.op;
  assign o_commit_addr = s_q.req.addr;
  assign o_commit_word0 = s_q.w0;
  assign o_commit_word1 = s_q.w1;
  assign o_boot_pending = s_q.boot;

  // Start is still high, with done still low, on the cycle after it rises.
  a_start_held: assert property (@(posedge i_clk) disable iff (!i_por_b)
    $rose(s_q.start) |=> s_q.start throughout (!done [*1]))
    else $error("start dropped early");
  // Completion clears the start bit on the next edge.
  a_start_clear: assert property (@(posedge i_clk) disable iff (!i_por_b)
    done |=> !s_q.start)
    else $error("start not cleared");
  // A launch in single-partition mode stalls the core.
  a_stall_single: assert property (@(posedge i_clk) disable iff (!i_por_b)
    s_d.go && !i_dual_mode |=> o_stall)
    else $error("no stall");
  // An inactive-partition erase leaves the core running.
  a_no_stall_dual: assert property (@(posedge i_clk) disable iff (!i_por_b)
    s_d.go && i_dual_mode && i_wdata[3:0] == fpes_pkg::OP_INACT_ERASE |=> !o_stall)
    else $error("stall on inactive erase");
  // A launch needs the enable bit already set.
  a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_por_b)
    s_d.go |-> s_q.enable)
    else $error("launch while disabled");
  // A launch needs the key pair just before it.
  a_key_gate: assert property (@(posedge i_clk) disable iff (!i_por_b)
    s_d.go |-> s_q.key == fpes_pkg::FPES_ARMED)
    else $error("launch unkeyed");
  // A refused start while idle raises the error flag.
  a_bad_start_err: assert property (@(posedge i_clk) disable iff (!i_por_b)
    i_wr && i_addr == fpes_pkg::ADDR_CTRL && i_wdata[fpes_pkg::BIT_START] && !s_d.go
    && s_q.run == fpes_pkg::FPES_RUN_IDLE |=> s_q.seqerr)
    else $error("no error");
  // Swap status reads zero in single-partition mode.
  a_swap_single: assert property (@(posedge i_clk) disable iff (!i_por_b)
    !i_dual_mode && i_rd && i_addr == fpes_pkg::ADDR_CTRL |=> !o_rdata[fpes_pkg::BIT_SWAP])
    else $error("swap shown in single mode");
  // Chip erase ignores the programmed target address.
  a_fixed_addr: assert property (@(posedge i_clk) disable iff (!i_por_b)
    s_d.go && i_wdata[3:0] == fpes_pkg::OP_CHIP_ERASE |=> o_commit_addr == fpes_pkg::FIXED_ADDR)
    else $error("chip erase used address");
  // Partition status reads zero in single-partition mode.
  a_p2_single: assert property (@(posedge i_clk) disable iff (!i_por_b)
    !i_dual_mode && i_rd && i_addr == fpes_pkg::ADDR_CTRL |=> !o_rdata[fpes_pkg::BIT_P2ACT])
    else $error("partition shown in single mode");
  // The key register never reads back.
  a_key_hidden: assert property (@(posedge i_clk) disable iff (!i_por_b)
    i_rd && i_addr == fpes_pkg::ADDR_KEY |=> o_rdata == fpes_pkg::ZERO16)
    else $error("key read back");
  // Unimplemented or disallowed codes never launch.
  a_illegal_op: assert property (@(posedge i_clk) disable iff (!i_por_b)
    i_wr && i_addr == fpes_pkg::ADDR_CTRL && !op_legal(i_wdata[3:0], i_dual_mode) |-> !s_d.go)
    else $error("illegal code launched");
  // The inactive-partition erase never launches in single-partition mode.
  a_inact_single: assert property (@(posedge i_clk) disable iff (!i_por_b)
    !i_dual_mode && i_wdata[3:0] == fpes_pkg::OP_INACT_ERASE |-> !s_d.go)
    else $error("inactive erase in single mode");
  // A successful launch clears the error flag.
  a_err_clear: assert property (@(posedge i_clk) disable iff (!i_por_b)
    s_d.go |=> !s_q.seqerr)
    else $error("error flag kept");
  // Completion commits the latches for exactly one cycle.
  a_commit_done: assert property (@(posedge i_clk) disable iff (!i_por_b)
    done |=> o_commit)
    else $error("no commit at done");
  a_commit_pulse: assert property (@(posedge i_clk) disable iff (!i_por_b)
    o_commit |=> !o_commit)
    else $error("commit longer than a cycle");
  // Completion releases the core, and a stall only stands during an operation.
  a_stall_release: assert property (@(posedge i_clk) disable iff (!i_por_b)
    done |=> !o_stall)
    else $error("stall kept after done");
  a_stall_busy: assert property (@(posedge i_clk) disable iff (!i_por_b)
    o_stall |-> o_busy)
    else $error("stall without operation");
  // A finished boot word write stays pending until power-on.
  a_boot_pend: assert property (@(posedge i_clk) disable iff (!i_por_b)
    done && s_q.req.op == fpes_pkg::OP_BOOT_CFG |=> o_boot_pending)
    else $error("boot word not pending");
  // Warm reset clears swap status and keeps the control fields.
  a_warm_swap: assert property (@(posedge i_clk) disable iff (!i_por_b)
    !i_rst_b |=> !s_q.swap)
    else $error("swap kept over warm reset");
  a_warm_keep: assert property (@(posedge i_clk) disable iff (!i_por_b)
    !i_rst_b && !i_wr |=> $stable(s_q.enable) && $stable(s_q.op))
    else $error("control changed by warm reset");
endmodule

// ### tb/fpes_core_model.sv
// Core-side model that issues register writes and reads on the plain register port.
`timescale 1ns/100ps
module fpes_core_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [2:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // Idle bus at time zero.
  initial begin
    o_addr = 3'h0;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write; idle cycles between two key writes are not accesses.
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;  // Released data never shows the last value.
  endtask

  // One-cycle read; data is taken in the cycle after the strobe.
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule

// ### tb/test_flash_program_erase_sequencer.sv
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/100ps
module test_flash_program_erase_sequencer;
  localparam int OPC = 4;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_por_b = 1'b0;
  logic i_dual_mode = 1'b0;
  logic i_swap_event = 1'b0;
  logic i_p2_active = 1'b0;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic stall;
  logic busy;
  logic commit;
  logic [3:0] c_op;
  logic [23:0] c_addr;
  logic [23:0] c_w0;
  logic [23:0] c_w1;
  logic boot_pend;
  logic [15:0] r;
  logic [23:0] w0;
  logic [23:0] w1;
  logic [3:0] op;
  int failures = 0;
  int n_compared = 0;
  int n_commit = 0;
  int seed = 10536;

  fpes_seq #(.OP_CYC(OPC), .NWORDS(fpes_pkg::LATCH_WORDS)) u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b), .i_dual_mode(i_dual_mode),
    .i_swap_event(i_swap_event), .i_p2_active(i_p2_active), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_stall(stall),
    .o_busy(busy), .o_commit(commit), .o_commit_op(c_op), .o_commit_addr(c_addr),
    .o_commit_word0(c_w0), .o_commit_word1(c_w1), .o_boot_pending(boot_pend)
  );
  fpes_core_model u_core (
    .i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );

  // Clock at 200 MHz.
  always #2.5 i_clk = ~i_clk;

  // Counts commit pulses while they stand, away from the launching edge.
  always @(negedge i_clk) begin
    if (commit === 1'b1) n_commit++;
  end

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic c, input string m);
    n_compared++;
    if (c !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // Tells whether an operation code may launch in the given mode.
  function automatic logic legal(input logic [3:0] o, input logic dual);
    return o inside {4'h1, 4'h2, 4'h3, 4'h8, 4'he} || (o == 4'h4 && dual);
  endfunction

  // Unlocks and launches one operation, then polls the start bit until clear.
  task automatic launch(input logic [3:0] o, input logic en, input logic ok, input logic st);
    int c0;
    c0 = n_commit;
    u_core.wr_reg(fpes_pkg::ADDR_CTRL, {1'b0, en, 10'h000, o});
    // Keys and start follow each other with nothing in between, as with interrupts held.
    u_core.wr_reg(fpes_pkg::ADDR_KEY, {8'h00, fpes_pkg::KEY_FIRST});
    u_core.wr_reg(fpes_pkg::ADDR_KEY, {8'h00, fpes_pkg::KEY_SECOND});
    u_core.wr_reg(fpes_pkg::ADDR_CTRL, {12'hc00, o});
    #1;
    chk(busy === ok, "busy after start write");
    chk(stall === (ok & st), "stall after start write");
    repeat (2) @(posedge i_clk);
    r = 16'hffff;
    for (int i = 0; i < 2 * OPC + 8; i++) begin
      if (r[15] !== 1'b0) u_core.rd_reg(fpes_pkg::ADDR_CTRL, r);
    end
    chk(r[15] === 1'b0 && stall === 1'b0, "start bit not cleared");
    chk(r[13] === !ok, "sequence error flag");
    if (ok) chk(c_op === o, "committed operation");
    chk(n_commit == c0 + int'(ok), "commit pulse count");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge i_clk);
    i_por_b <= 1'b1;
    i_rst_b <= 1'b1;
    u_core.rd_reg(fpes_pkg::ADDR_CTRL, r);
    chk(r === 16'h0000, "control reset value");
    u_core.rd_reg(fpes_pkg::ADDR_KEY, r);
    chk(r === 16'h0000, "key reads zero");
    $display("test reset done");
    w0 = 24'($random(seed));
    w1 = 24'($random(seed));
    // The latch index port stands for the table page that points at the latches.
    u_core.wr_reg(fpes_pkg::ADDR_LATCH_IDX, 16'h0000);
    u_core.wr_reg(fpes_pkg::ADDR_LATCH_LO, w0[15:0]);
    u_core.wr_reg(fpes_pkg::ADDR_LATCH_HI, {8'h00, w0[23:16]});
    u_core.wr_reg(fpes_pkg::ADDR_LATCH_IDX, 16'h0001);
    u_core.wr_reg(fpes_pkg::ADDR_LATCH_LO, w1[15:0]);
    u_core.wr_reg(fpes_pkg::ADDR_LATCH_HI, {8'h00, w1[23:16]});
    u_core.wr_reg(fpes_pkg::ADDR_ADR_LO, w1[15:0]);
    u_core.wr_reg(fpes_pkg::ADDR_ADR_HI, {8'h00, w0[7:0]});
    chk(commit === 1'b0 && n_commit == 0, "latch writes commit nothing");
    launch(fpes_pkg::OP_DWORD, 1'b1, 1'b1, 1'b1);
    chk(c_w0 === w0 && c_w1 === w1, "latch words committed");
    chk(c_addr === {w0[7:0], w1[15:0]}, "target address");
    // The page erase comes before the row program that needs it.
    for (int i = 0; i < 4; i++) begin
      op = (i == 0) ? 4'h3 : (i == 1) ? 4'h2 : (i == 2) ? 4'he : 4'h8;
      launch(op, 1'b1, 1'b1, 1'b1);
      if (op == 4'he) chk(c_addr === fpes_pkg::FIXED_ADDR, "fixed address");
    end
    chk(boot_pend === 1'b1, "boot word pending");
    $display("test operations done");
    launch(fpes_pkg::OP_INACT_ERASE, 1'b1, 1'b0, 1'b1);
    launch(fpes_pkg::OP_PAGE_ERASE, 1'b0, 1'b0, 1'b1);
    repeat (6) begin
      op = 4'($random(seed));
      if (!legal(op, 1'b0)) launch(op, 1'b1, 1'b0, 1'b1);
    end
    u_core.wr_reg(fpes_pkg::ADDR_CTRL, 16'h4001);
    u_core.wr_reg(fpes_pkg::ADDR_CTRL, 16'hc001);
    #1;
    chk(busy === 1'b0, "start without keys");
    $display("test refusals done");
    i_dual_mode <= 1'b1;
    i_p2_active <= 1'b1;
    launch(fpes_pkg::OP_INACT_ERASE, 1'b1, 1'b1, 1'b0);
    @(posedge i_clk);
    i_swap_event <= 1'b1;
    @(posedge i_clk);
    i_swap_event <= 1'b0;
    u_core.rd_reg(fpes_pkg::ADDR_CTRL, r);
    chk(r[11] === 1'b1 && r[10] === 1'b1, "dual swap and partition");
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    u_core.rd_reg(fpes_pkg::ADDR_CTRL, r);
    chk(r[11] === 1'b0 && r[14] === 1'b1 && r[3:0] === 4'h4, "warm reset");
    i_swap_event <= 1'b1;
    @(posedge i_clk);
    i_swap_event <= 1'b0;
    u_core.rd_reg(fpes_pkg::ADDR_CTRL, r);
    chk(r[11] === 1'b1, "swap set after warm reset");
    u_core.wr_reg(fpes_pkg::ADDR_CTRL, 16'h4004);
    u_core.rd_reg(fpes_pkg::ADDR_CTRL, r);
    chk(r[11] === 1'b0, "software clears swap");
    i_dual_mode <= 1'b0;
    u_core.rd_reg(fpes_pkg::ADDR_CTRL, r);
    chk(r[11:10] === 2'b00, "single mode status");
    $display("test partitions done");
    give_verdict();
  end
endmodule
